// [hdl/pin_sync3.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } sync_state_s;

  sync_state_s s_reg, s_next;

  if (WIDTH < 1) begin : g_check
    $error("pin_sync3 needs at least one bit");
  end

  always_comb begin
    s_next = s_reg;
    s_next.s1 = din;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    // take the value only once stages two and three agree
    s_next.stable = (s_reg.s2 & s_reg.s3) |
                    (s_reg.stable & (s_reg.s2 ^ s_reg.s3));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= {INIT, INIT, INIT, INIT};
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.stable;
endmodule // pin_sync3

// [hdl/uart_irq_ctrl.sv]
// uart channel interrupt enable, status and line status logic
`timescale 1ns/1ps
// Function
// - 16-bit divisor counter; divisor bytes reachable only with format bit 7 set.
// - fifo mode receive data interrupt while level at or above trigger.
// - receive ready status bit set on push, cleared when fifo empty.
// - fifo on with enables 0-3 clear gives polled mode via status bits.
// - line status bits: overrun, head errors, holding empty, all empty, any error.
// - timeout after four characters plus twelve bits idle below trigger.
// - non-fifo mode receive interrupt while holding register has data.
// - transmit interrupt follows holding empty, or all empty in half duplex.
// - line interrupt on pushed character with overrun, parity, framing, break.
// - enable bits 7..5 writable only when unlocked; bit 4 reserved.
// - input flow interrupt on rising selected clear-to-send or set-ready pin.
// - output flow interrupt when selected flow output rises.
// - status read shows highest pending source; others except transmit and character stay queued.
// - codes for line, receive data, timeout and transmit empty levels.
// - codes for modem, special character, flow pin and none.
// - modem interrupt while any delta bit set and enabled.
// - wake indication on sleep exit, cleared by global register read.
// - line status read clears line; modem read clears flow and pulses msr_read, modem deltas come from ev.
// - receive data clears below trigger; timeout clears when fifo empty.
// - status read clears transmit and character; special clears on next char.
// - enabled interrupts shown in status and in global register.
// - all enable bits reset to zero; writing one enables.
// - status bit 0 low while pending, high when none, high at reset.
// - status bits 7 and 6 mirror fifo enable.
module uart_irq_ctrl
  import uart_irq_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLES_PER_BIT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire rx_status_s rx,
  input wire tx_status_s tx,
  input wire event_s ev,
  input wire logic cts_n,
  input wire logic dsr_n,
  output logic irq,
  output logic sample_tick,
  output logic polled_mode,
  output logic fifo_enabled,
  output logic lsr_read,
  output logic msr_read,
  output logic [7:0] line_format,
  output logic [7:0] modem_ctrl,
  output logic [7:0] enhanced_ctrl,
  output logic [7:0] feature_ctrl
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [IDX_W-1:0] aw_idx;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rbyte;
    logic [1:0] rresp;
    logic [7:0] interrupt_enable;
    logic [7:0] line_format_reg;
    logic [7:0] modem_control;
    logic [7:0] enhanced_function_reg;
    logic [7:0] feature_control;
    logic [15:0] divisor;
    logic fifo_en;
    logic line_irq;
    logic overrun;
    logic tx_irq;
    logic tx_src_d;
    logic timeout_irq;
    logic xchar_irq;
    logic special;
    logic in_flow_irq;
    logic out_flow_irq;
    logic in_pin_d;
    logic out_pin_d;
    logic wake;
    logic [15:0] div_cnt;
    logic [3:0] samp_cnt;
    logic [6:0] idle_cnt;
  } state_s;

  state_s s_reg, s_next;

  if (SAMPLE_DIV < 1 || SAMPLE_DIV > 16) begin : g_check
    $error("SAMPLE_DIV must lie in 1..16");
  end

  logic [1:0] pins_sync;
  logic wr_fire, rd_fire, bit_tick, tx_src, rx_has_data, rx_data_src;
  logic timeout_set, line_set, in_pin, out_pin, div_access;
  logic [IDX_W-1:0] ar_idx;
  logic [5:0] code;
  logic [7:0] isr_val, lsr_val, rd_byte;
  logic [1:0] rd_resp, wr_resp;
  logic [6:0] char_bits, tmo_limit;

  // {dsr_n, cts_n}; idle high
  pin_sync3 #(.WIDTH(2), .INIT(2'h3)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({dsr_n, cts_n}),
    .dout(pins_sync)
  );

  assign ar_idx = araddr[7:2];
  assign awready = !s_reg.aw_got && !s_reg.bvalid;
  assign wready = !s_reg.w_got && !s_reg.bvalid;
  assign arready = !s_reg.rvalid;
  assign rd_fire = arvalid && arready;
  assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
  assign div_access = s_reg.line_format_reg[LCR_DIV_ACCESS];

  // start + data + parity + stop, in bit times
  assign char_bits = 7'd1 + 7'(MIN_DATA_BITS) + {5'h0, s_reg.line_format_reg[1:0]} +
                     {6'h0, s_reg.line_format_reg[LCR_PARITY]} +
                     (s_reg.line_format_reg[LCR_STOP] ? 7'd2 : 7'd1);
  assign tmo_limit = 7'(TIMEOUT_CHARS) * char_bits +
                     7'(TIMEOUT_EXTRA_BITS);

  assign sample_tick = (s_reg.divisor != 16'h0000) &&
                       (s_reg.div_cnt == 16'h0000);
  assign bit_tick = sample_tick &&
                    (s_reg.samp_cnt == 4'(SAMPLE_DIV - 1));

  assign rx_has_data = rx.level != '0;
  assign rx_data_src = s_reg.fifo_en ?
                       (rx_has_data && rx.level >= rx.trigger) :
                       rx_has_data;
  assign tx_src = s_reg.feature_control[FEATURE_CONTROL_HALF_DUPLEX] ?
                  tx.all_empty : tx.holding_empty;
  assign line_set = (rx.char_pushed && (|rx.push_err)) ||
                    rx.push_overrun;
  assign timeout_set = s_reg.fifo_en && rx_has_data &&
                       rx.level < rx.trigger && !rx.line_active &&
                       bit_tick && (s_reg.idle_cnt == tmo_limit - 7'd1);
  assign in_pin = s_reg.modem_control[MCR_FLOW_SEL] ? pins_sync[1] : pins_sync[0];
  assign out_pin = s_reg.modem_control[MCR_FLOW_SEL] ? ev.dtr_n_out : ev.rts_n_out;

  // highest enabled pending source wins; lower ones stay queued, except transmit and character, which any status read clears
  always_comb begin
    if (s_reg.line_irq && s_reg.interrupt_enable[IER_LINE]) begin
      code = CODE_LINE;
    end else if (rx_data_src && s_reg.interrupt_enable[IER_RX]) begin
      code = CODE_RX_DATA;
    end else if (s_reg.timeout_irq && s_reg.interrupt_enable[IER_RX]) begin
      code = CODE_TIMEOUT;
    end else if (s_reg.tx_irq && s_reg.interrupt_enable[IER_TX]) begin
      code = CODE_TX_EMPTY;
    end else if ((|ev.modem_status[3:0]) && s_reg.interrupt_enable[IER_MODEM]) begin
      code = CODE_MODEM;
    end else if (s_reg.xchar_irq && s_reg.interrupt_enable[IER_XCHAR]) begin
      code = CODE_XCHAR;
    end else if ((s_reg.in_flow_irq && s_reg.interrupt_enable[IER_IN_FLOW]) ||
                 (s_reg.out_flow_irq && s_reg.interrupt_enable[IER_OUT_FLOW])) begin
      code = CODE_FLOW_PIN;
    end else begin
      code = CODE_NONE;
    end
  end

  assign isr_val = {s_reg.fifo_en, s_reg.fifo_en, code};
  assign lsr_val = {rx.any_err, tx.all_empty, tx.holding_empty,
                    rx.head_err, s_reg.overrun, rx_has_data};

  always_comb begin
    rd_resp = RESP_OKAY;
    unique case (ar_idx)
      IDX_DIV_LOW: rd_byte = div_access ? s_reg.divisor[7:0] : 8'h00;
      IDX_IER: rd_byte = div_access ? s_reg.divisor[15:8] : s_reg.interrupt_enable;
      IDX_ISR: rd_byte = isr_val;
      IDX_LCR: rd_byte = s_reg.line_format_reg;
      IDX_MCR: rd_byte = s_reg.modem_control;
      IDX_LSR: rd_byte = lsr_val;
      IDX_MSR: rd_byte = ev.modem_status;
      IDX_FEATURE_CONTROL: rd_byte = s_reg.feature_control;
      IDX_EFR: rd_byte = s_reg.enhanced_function_reg;
      IDX_GLOBAL: rd_byte = {6'h00, s_reg.wake, irq};
      default: begin
        rd_byte = 8'h00;
        rd_resp = RESP_SLVERR;
      end
    endcase
  end

  always_comb begin
    unique case (s_reg.aw_idx)
      IDX_DIV_LOW, IDX_IER, IDX_ISR, IDX_LCR, IDX_MCR, IDX_LSR,
      IDX_MSR, IDX_FEATURE_CONTROL, IDX_EFR: wr_resp = RESP_OKAY;
      default: wr_resp = RESP_SLVERR;
    endcase
  end

  assign lsr_read = rd_fire && ar_idx == IDX_LSR;
  assign msr_read = rd_fire && ar_idx == IDX_MSR;

  always_comb begin
    s_next = s_reg;
    // bus side
    if (awvalid && awready) begin
      s_next.aw_got = 1'b1;
      s_next.aw_idx = awaddr[7:2];
    end
    if (wvalid && wready) begin
      s_next.w_got = 1'b1;
      s_next.wbyte = wdata[7:0];
      s_next.wlane = wstrb[0];
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = wr_resp;
    end
    if (wr_fire && s_reg.wlane) begin
      unique case (s_reg.aw_idx)
        IDX_DIV_LOW: begin
          if (div_access) begin
            s_next.divisor[7:0] = s_reg.wbyte;
          end
        end
        IDX_IER: begin
          if (div_access) begin
            s_next.divisor[15:8] = s_reg.wbyte;
          end else begin
            s_next.interrupt_enable = (s_reg.wbyte & IER_OPEN_MASK) |
                         ((s_reg.enhanced_function_reg[EFR_UNLOCK] ? s_reg.wbyte : s_reg.interrupt_enable)
                          & IER_LOCKED_MASK);
          end
        end
        IDX_ISR: s_next.fifo_en = s_reg.wbyte[FCR_FIFO_EN];
        IDX_LCR: s_next.line_format_reg = s_reg.wbyte;
        IDX_MCR: s_next.modem_control = s_reg.wbyte;
        IDX_FEATURE_CONTROL: s_next.feature_control = s_reg.wbyte;
        IDX_EFR: s_next.enhanced_function_reg = s_reg.wbyte;
        default: s_next.fifo_en = s_reg.fifo_en;
      endcase
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rbyte = rd_byte;
      s_next.rresp = rd_resp;
    end
    // rate divider
    if (sample_tick) begin
      s_next.div_cnt = s_reg.divisor - 16'h0001;
      s_next.samp_cnt = bit_tick ? 4'h0 : s_reg.samp_cnt + 4'h1;
    end else if (s_reg.div_cnt != 16'h0000) begin
      s_next.div_cnt = s_reg.div_cnt - 16'h0001;
    end else begin
      s_next.div_cnt = s_reg.divisor;
    end
    // clears first, so a same-cycle set below wins
    if (lsr_read) begin
      s_next.line_irq = 1'b0;
      s_next.overrun = 1'b0;
    end
    if (msr_read) begin
      s_next.in_flow_irq = 1'b0;
      s_next.out_flow_irq = 1'b0;
    end
    if ((rd_fire && ar_idx == IDX_ISR) || !tx_src) begin
      s_next.tx_irq = 1'b0;
    end
    if ((rd_fire && ar_idx == IDX_ISR) ||
        (s_reg.special && rx.char_pushed)) begin
      s_next.xchar_irq = 1'b0;
      s_next.special = 1'b0;
    end
    if (rd_fire && ar_idx == IDX_GLOBAL) begin
      s_next.wake = 1'b0;
    end
    if (!rx_has_data) begin
      s_next.timeout_irq = 1'b0;
    end
    // sets
    if (line_set) begin
      s_next.line_irq = 1'b1;
    end
    if (rx.push_overrun) begin
      s_next.overrun = 1'b1;
    end
    s_next.tx_src_d = tx_src;
    if (tx_src && !s_reg.tx_src_d) begin
      s_next.tx_irq = 1'b1;
    end
    if (ev.xchar_det || ev.special_det) begin
      s_next.xchar_irq = 1'b1;
      s_next.special = ev.special_det;
    end
    s_next.in_pin_d = in_pin;
    if (s_reg.enhanced_function_reg[EFR_AUTO_IN] && in_pin && !s_reg.in_pin_d) begin
      s_next.in_flow_irq = 1'b1;
    end
    s_next.out_pin_d = out_pin;
    if (s_reg.enhanced_function_reg[EFR_AUTO_OUT] && out_pin && !s_reg.out_pin_d) begin
      s_next.out_flow_irq = 1'b1;
    end
    if (ev.sleep_exit) begin
      s_next.wake = 1'b1;
    end
    // idle timer in bit times
    if (rx.char_pushed || rx.fifo_read || rx.line_active) begin
      s_next.idle_cnt = 7'h00;
    end else if (bit_tick && s_reg.idle_cnt != tmo_limit) begin
      s_next.idle_cnt = s_reg.idle_cnt + 7'h01;
    end
    if (timeout_set) begin
      s_next.timeout_irq = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign irq = code != CODE_NONE;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign rvalid = s_reg.rvalid;
  assign rdata = {24'h000000, s_reg.rbyte};
  assign rresp = s_reg.rresp;
  assign polled_mode = s_reg.fifo_en &&
                       s_reg.interrupt_enable[3:0] == 4'h0;
  assign fifo_enabled = s_reg.fifo_en;
  assign line_format = s_reg.line_format_reg;
  assign modem_ctrl = s_reg.modem_control;
  assign enhanced_ctrl = s_reg.enhanced_function_reg;
  assign feature_ctrl = s_reg.feature_control;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence isr_read_s;
    rd_fire && ar_idx == IDX_ISR;
  endsequence
  sequence lsr_read_s;
    rd_fire && ar_idx == IDX_LSR;
  endsequence

  ier_reset_a: assert property (disable iff (1'b0)
    !aresetn |=> s_reg.interrupt_enable == 8'h00 && isr_val[0])
    else $error("enables not cleared by reset");
  none_flag_a: assert property (irq != isr_val[0])
    else $error("status bit 0 disagrees with pending");
  fifo_bits_a: assert property ($rose(s_reg.fifo_en) |->
    isr_val[7:6] == 2'h3 && $past(isr_val[7:6]) == 2'h0)
    else $error("fifo bits do not follow enable");
  line_prio_a: assert property (s_reg.line_irq && s_reg.interrupt_enable[IER_LINE]
    |-> code == CODE_LINE && irq)
    else $error("line status not reported first");
  lsr_clear_a: assert property (lsr_read_s ##0 !line_set
    |=> !s_reg.line_irq ##1 (s_reg.line_irq -> $past(line_set)))
    else $error("line interrupt not cleared by line status read");
  tx_clear_a: assert property (isr_read_s ##0 !(tx_src && !s_reg.tx_src_d)
    |=> !s_reg.tx_irq)
    else $error("transmit interrupt not cleared by status read");
  tx_rise_a: assert property ($rose(tx_src) |=> s_reg.tx_irq)
    else $error("transmit empty not flagged");
  ier_lock_a: assert property (wr_fire && s_reg.aw_idx == IDX_IER &&
    !div_access && !s_reg.enhanced_function_reg[EFR_UNLOCK] |=> $stable(s_reg.interrupt_enable[7:5])
    && !s_reg.interrupt_enable[4])
    else $error("locked enables changed");
  timeout_a: assert property (timeout_set |=> s_reg.timeout_irq
    && s_reg.idle_cnt == tmo_limit)
    else $error("receive timeout not raised");
  timeout_clr_a: assert property (s_reg.timeout_irq && !rx_has_data
    |=> !s_reg.timeout_irq)
    else $error("timeout not cleared on empty fifo");
  ready_bit_a: assert property (rx.char_pushed |-> ##[0:1]
    lsr_val[0])
    else $error("receive ready bit missing");
  div_lock_a: assert property (wr_fire && !div_access &&
    s_reg.aw_idx == IDX_DIV_LOW |=> $stable(s_reg.divisor))
    else $error("divisor written while hidden");
  wake_a: assert property (ev.sleep_exit |=> s_reg.wake)
    else $error("wake indication lost");
endmodule // uart_irq_ctrl

// [include/uart_irq_pkg.sv]
// constants and carrier types for the uart interrupt enable/status block
package uart_irq_pkg;
  localparam int LEVEL_W = 7;
  localparam int IDX_W = 6;
  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DIV_LOW = 6'h00;
  localparam logic [IDX_W-1:0] IDX_IER = 6'h01;
  localparam logic [IDX_W-1:0] IDX_ISR = 6'h02;
  localparam logic [IDX_W-1:0] IDX_LCR = 6'h03;
  localparam logic [IDX_W-1:0] IDX_MCR = 6'h04;
  localparam logic [IDX_W-1:0] IDX_LSR = 6'h05;
  localparam logic [IDX_W-1:0] IDX_MSR = 6'h06;
  localparam logic [IDX_W-1:0] IDX_FEATURE_CONTROL = 6'h08;
  localparam logic [IDX_W-1:0] IDX_EFR = 6'h09;
  localparam logic [IDX_W-1:0] IDX_GLOBAL = 6'h10;
  // field positions
  localparam int LCR_DIV_ACCESS = 7;
  localparam int LCR_PARITY = 3;
  localparam int LCR_STOP = 2;
  localparam int EFR_UNLOCK = 4;
  localparam int EFR_AUTO_OUT = 6;
  localparam int EFR_AUTO_IN = 7;
  localparam int FEATURE_CONTROL_HALF_DUPLEX = 5;
  localparam int MCR_FLOW_SEL = 2;
  localparam int FCR_FIFO_EN = 0;
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LINE = 2;
  localparam int IER_MODEM = 3;
  localparam int IER_XCHAR = 5;
  localparam int IER_OUT_FLOW = 6;
  localparam int IER_IN_FLOW = 7;
  localparam logic [7:0] IER_OPEN_MASK = 8'h0F;
  localparam logic [7:0] IER_LOCKED_MASK = 8'hE0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // interrupt source codes, status bits 5..0
  localparam logic [5:0] CODE_LINE = 6'h06;
  localparam logic [5:0] CODE_RX_DATA = 6'h04;
  localparam logic [5:0] CODE_TIMEOUT = 6'h0C;
  localparam logic [5:0] CODE_TX_EMPTY = 6'h02;
  localparam logic [5:0] CODE_MODEM = 6'h00;
  localparam logic [5:0] CODE_XCHAR = 6'h10;
  localparam logic [5:0] CODE_FLOW_PIN = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;
  // receive timeout, in character and bit times
  localparam int TIMEOUT_CHARS = 4;
  localparam int TIMEOUT_EXTRA_BITS = 12;
  localparam int SAMPLES_PER_BIT = 16;
  localparam int MIN_DATA_BITS = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [LEVEL_W-1:0] level;
    logic [LEVEL_W-1:0] trigger;
    logic char_pushed;
    logic push_overrun;
    logic [2:0] push_err;
    logic [2:0] head_err;
    logic any_err;
    logic line_active;
    logic fifo_read;
  } rx_status_s;

  typedef struct packed {
    logic holding_empty;
    logic all_empty;
  } tx_status_s;

  typedef struct packed {
    logic [7:0] modem_status;
    logic xchar_det;
    logic special_det;
    logic sleep_exit;
    logic rts_n_out;
    logic dtr_n_out;
  } event_s;
endpackage

// [tb/axi_host.sv]
// register bus master standing in for host software
`timescale 1ns/1ps
module axi_host (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic hung
);
  // response code of the last write, read by the bench
  logic [1:0] last_b;
  initial begin
    last_b = 2'h3;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hung} = '0;
  end
  // local flags track each channel, since nba values land after the test
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bit a, w, b;
    int n;
    a = 1;
    w = 1;
    b = 1;
    n = 0;
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((a || w || b) && n < 60) begin
      @(posedge aclk);
      n++;
      if (b && !a && !w && bvalid) begin
        b = 0;
        bready <= 1'b0;
        last_b = bresp;
      end
      if (a && awready) begin
        a = 0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 1'b0;
      end
    end
    // one idle edge so the next call never re-raises bready in this step
    @(posedge aclk);
    if (n >= 60) hung = 1'b1;
  endtask
  task automatic rd(input logic [5:0] idx, output logic [7:0] d,
                    output logic [1:0] r);
    bit a, v;
    int n;
    a = 1;
    v = 1;
    n = 0;
    d = 8'h00;
    r = 2'h3;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while ((a || v) && n < 60) begin
      @(posedge aclk);
      n++;
      if (v && !a && rvalid) begin
        v = 0;
        rready <= 1'b0;
        d = rdata[7:0];
        r = rresp;
      end
      if (a && arready) begin
        a = 0;
        arvalid <= 1'b0;
      end
    end
    @(posedge aclk);
    if (n >= 60) hung = 1'b1;
  endtask
endmodule // axi_host

// [tb/tb.sv]
// self-checking bench for the uart interrupt enable/status block
`timescale 1ns/1ps
module tb;
  import uart_irq_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cts_n, dsr_n, irq, hung;
  logic polled_mode, fifo_enabled;
  logic [7:0] awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  rx_status_s rx;
  tx_status_s tx;
  event_s ev;
  int err_count, n_checks;
  // divisor of one sample per bit keeps the idle timeout short
  uart_irq_ctrl #(.SAMPLE_DIV(1)) u_dut (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .rx, .tx, .ev, .cts_n, .dsr_n, .irq, .sample_tick(), .polled_mode,
    .fifo_enabled, .lsr_read(), .msr_read(), .line_format(),
    .modem_ctrl(), .enhanced_ctrl(), .feature_ctrl());
  axi_host u_host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .hung);
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rc(input logic [5:0] idx, input logic [7:0] exp,
                    input string what);
    u_host.rd(idx, d, r);
    chk(what, d, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge hung) begin
    err_count++;
    conclude();
  end
  task automatic t_reset();
    rc(IDX_IER, 8'h00, "enable reset");
    rc(IDX_ISR, 8'h01, "status reset");
    chk("irq idle", {7'h00, irq}, 8'h00);
    u_host.rd(6'h3F, d, r);
    chk("unmapped resp", {6'h00, r}, {6'h00, RESP_SLVERR});
    u_host.wr(6'h3F, 8'h00);
    chk("unmapped wr", {6'h00, u_host.last_b}, {6'h00, RESP_SLVERR});
    u_host.wr(IDX_LCR, 8'h00);
    chk("mapped wr", {6'h00, u_host.last_b}, {6'h00, RESP_OKAY});
    $display("test reset done");
  endtask
  task automatic t_lock_div();
    u_host.wr(IDX_IER, 8'hFF);
    rc(IDX_IER, 8'h0F, "locked enables");
    u_host.wr(IDX_EFR, 8'h10);
    u_host.wr(IDX_IER, 8'hFF);
    rc(IDX_IER, 8'hEF, "unlocked enables");
    u_host.wr(IDX_LCR, 8'h80);
    u_host.wr(IDX_DIV_LOW, 8'h01);
    u_host.wr(IDX_IER, 8'h00);
    rc(IDX_DIV_LOW, 8'h01, "divisor open");
    u_host.wr(IDX_LCR, 8'h00);
    rc(IDX_DIV_LOW, 8'h00, "divisor hidden");
    rc(IDX_IER, 8'hEF, "enable kept");
    $display("test lock done");
  endtask
  task automatic t_prio();
    u_host.wr(IDX_IER, 8'h00);
    u_host.wr(IDX_ISR, 8'h01);
    chk("polled", {7'h00, polled_mode}, 8'h01);
    rc(IDX_ISR, 8'hC1, "fifo bits");
    u_host.wr(IDX_IER, 8'hEF);
    ev.modem_status <= 8'h01;
    cyc(2);
    rc(IDX_ISR, 8'hC0, "modem");
    chk("irq on", {7'h00, irq}, 8'h01);
    tx.holding_empty <= 1'b1;
    cyc(2);
    rc(IDX_ISR, 8'hC2, "tx over modem");
    rc(IDX_ISR, 8'hC0, "tx cleared");
    rx.level <= 7'd2;
    cyc(2);
    rc(IDX_ISR, 8'hC4, "rx data");
    rx.char_pushed <= 1'b1;
    rx.push_overrun <= 1'b1;
    rx.push_err <= 3'b101;
    rx.head_err <= 3'b101;
    rx.any_err <= 1'b1;
    cyc(1);
    {rx.char_pushed, rx.push_overrun, rx.push_err} <= '0;
    cyc(2);
    rc(IDX_ISR, 8'hC6, "line first");
    rc(IDX_LSR, 8'hB7, "line bits");
    rc(IDX_ISR, 8'hC4, "line cleared");
    rx.level <= 7'd1;
    cyc(2);
    rc(IDX_ISR, 8'hC0, "rx below");
    ev.modem_status <= 8'h00;
    ev.xchar_det <= 1'b1;
    cyc(1);
    ev.xchar_det <= 1'b0;
    cyc(2);
    rc(IDX_ISR, 8'hD0, "xon xoff");
    rc(IDX_ISR, 8'hC1, "xchar cleared");
    ev.special_det <= 1'b1;
    cyc(1);
    ev.special_det <= 1'b0;
    rx.char_pushed <= 1'b1;
    cyc(1);
    rx.char_pushed <= 1'b0;
    cyc(2);
    rc(IDX_ISR, 8'hC1, "special by char");
    chk("irq off", {7'h00, irq}, 8'h00);
    $display("test priority done");
  endtask
  task automatic t_timeout();
    // 5 data bits, 1 stop: 4*(1+5+1)+12 = 40 bit times of one cycle
    rx.line_active <= 1'b0;
    cyc(15);
    rc(IDX_ISR, 8'hC1, "no timeout yet");
    cyc(40);
    rc(IDX_ISR, 8'hCC, "timeout");
    rc(IDX_ISR, 8'hCC, "timeout held");
    rx.level <= 7'd0;
    cyc(2);
    rc(IDX_ISR, 8'hC1, "timeout cleared");
    $display("test timeout done");
  endtask
  task automatic t_flow_wake();
    u_host.wr(IDX_EFR, 8'h90);
    cts_n <= 1'b0;
    cyc(10);
    cts_n <= 1'b1;
    cyc(10);
    rc(IDX_ISR, 8'hE0, "cts rise");
    u_host.rd(IDX_MSR, d, r);
    rc(IDX_ISR, 8'hC1, "flow cleared");
    ev.sleep_exit <= 1'b1;
    cyc(1);
    ev.sleep_exit <= 1'b0;
    cyc(2);
    u_host.rd(IDX_GLOBAL, d, r);
    chk("wake set", d & 8'h02, 8'h02);
    u_host.rd(IDX_GLOBAL, d, r);
    chk("wake cleared", d & 8'h02, 8'h00);
    $display("test flow done");
  endtask
  task automatic t_modes();
    u_host.wr(IDX_EFR, 8'hD0);
    ev.rts_n_out <= 1'b1;
    cyc(2);
    rc(IDX_ISR, 8'hE0, "rts rise");
    u_host.rd(IDX_MSR, d, r);
    u_host.wr(IDX_FEATURE_CONTROL, 8'h20);
    tx.all_empty <= 1'b1;
    cyc(2);
    rc(IDX_ISR, 8'hC2, "half duplex tx");
    u_host.wr(IDX_ISR, 8'h00);
    chk("fifo off", {7'h00, fifo_enabled}, 8'h00);
    rx.level <= 7'd1;
    cyc(2);
    rc(IDX_ISR, 8'h04, "non-fifo rx");
    u_host.rd(IDX_GLOBAL, d, r);
    chk("global irq", d & 8'h01, 8'h01);
    $display("test modes done");
  endtask
  initial begin
    err_count = 0;
    n_checks = 0;
    aresetn = 1'b0;
    rx = '0;
    rx.trigger = 7'd2;
    rx.line_active = 1'b1;
    tx = '0;
    ev = '0;
    cts_n = 1'b1;
    dsr_n = 1'b1;
    cyc(12);
    aresetn <= 1'b1;
    cyc(1);
    t_reset();
    t_lock_div();
    t_prio();
    t_timeout();
    t_flow_wake();
    t_modes();
    conclude();
  end
endmodule // tb
